//--- mag_axis_eval.sv
// one axis: overflow saturation and comparison with the scaled upper limit
`timescale 1ns/10ps
`default_nettype none
module mag_axis_eval
  import mag_irq_pkg::*;
#(
  parameter logic signed [VERT_WIDTH-1:0] SAT_CODE = SAT_HORIZ
) (
  input wire logic signed [VERT_WIDTH-1:0] raw, // sign-extended raw value
  input wire logic overflow, // axis overflowed this sample
  input wire logic [7:0] limit, // upper limit level
  output logic signed [VERT_WIDTH-1:0] value, // value to store
  output logic above // raw strictly above limit times 16, and the axis not overflowed
);

  // ---------------------------------------------------------------
  // saturation and compare
  // ---------------------------------------------------------------
  wire logic signed [VERT_WIDTH-1:0] scaled_limit;

  // limit times 16 never exceeds 4080 and is zero-extended, so it is never negative here
  assign scaled_limit = $signed({{(VERT_WIDTH-8-LIMIT_SHIFT){1'b0}},
                                 limit, {LIMIT_SHIFT{1'b0}}});
  assign value = overflow ? SAT_CODE : raw;
  assign above = !overflow && (raw > scaled_limit);

endmodule
`default_nettype wire

//--- mag_host_model.sv
// host model: register reads and writes on the request port
`timescale 1ns/10ps
`default_nettype none
module mag_host_model
  import mag_irq_pkg::*;
(
  input wire logic sys_clk, // clock
  output var reg_req_t req, // request to the device
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid, // read valid
  input wire logic reg_rdrive // read drive
);
  initial req = '0;
  // one-cycle write; released fields are inverted so stale data shows
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge sys_clk);
    #1;
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask
  // one-cycle read; the answer stands only in the following cycle
  task automatic read(input logic [7:0] a, output logic [7:0] d,
    output logic dr);
    @(posedge sys_clk);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge sys_clk);
    #1;
    req.rd = 1'b0;
    req.addr = ~a;
    d = reg_rvalid ? reg_rdata : 8'hxx;
    dr = reg_rdrive;
  endtask
  task automatic find_overflow(output logic [2:0] s);
    logic [7:0] lo, hi;
    logic dr;
    for (int i = 0; i < NUM_AXES; i++) begin
      read(ADDR_AXIS_ONE_LSB + 8'(2 * i), lo, dr);
      read(ADDR_AXIS_ONE_MSB + 8'(2 * i), hi, dr);
      s[i] = (hi === 8'h80) && (lo === 8'h00);
    end
  endtask
endmodule
`default_nettype wire

//--- mag_irq_ctrl.sv
// magnetometer high-threshold and overflow interrupt with its registers
`timescale 1ns/10ps
`default_nettype none
module mag_irq_ctrl
  import mag_irq_pkg::*;
(
  input wire logic sys_clk, // 100 MHz system clock
  input wire logic rst, // asynchronous reset, active high
  input wire meas_sample_t sample, // finished measurement
  input wire reg_req_t req, // register access request
  output logic [7:0] reg_rdata, // read data, one cycle after rd
  output logic reg_rvalid, // read data valid pulse
  output logic reg_rdrive, // read data output enable
  output logic irq_out, // interrupt pin level
  output logic irq_oe // interrupt pin output enable
);

  // ---------------------------------------------------------------
  // stored state
  // ---------------------------------------------------------------
  logic signed [VERT_WIDTH-1:0] axis_value [NUM_AXES];
  logic [7:0] irq_status_flags;
  logic [7:0] irq_enable_bits;
  logic [7:0] pin_config;
  logic [7:0] lower_limit_level;
  logic [7:0] upper_limit_level;
  logic ready_status;

  // ---------------------------------------------------------------
  // per-axis evaluation
  // ---------------------------------------------------------------
  wire logic signed [VERT_WIDTH-1:0] axis_raw [NUM_AXES];
  wire logic signed [VERT_WIDTH-1:0] axis_next [NUM_AXES];
  wire logic [NUM_AXES-1:0] axis_above;
  wire logic [NUM_AXES-1:0] high_enabled;

  // horizontal axes are narrower, sign-extend to a common width
  assign axis_raw[0] = VERT_WIDTH'(sample.field_value_axis_one);
  assign axis_raw[1] = VERT_WIDTH'(sample.field_value_axis_two);
  assign axis_raw[2] = sample.field_value_axis_three;

  assign high_enabled = ~irq_enable_bits[BIT_HIGH_FIRST +: NUM_AXES];

  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : g_axis
      mag_axis_eval #(
        .SAT_CODE((g == NUM_AXES - 1) ? SAT_VERT : SAT_HORIZ)
      ) u_eval (
        .raw(axis_raw[g]),
        .overflow(sample.overflow[g]),
        .limit(upper_limit_level),
        .value(axis_next[g]),
        .above(axis_above[g])
      );

      // field data registers load with each new sample
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          axis_value[g] <= '0;
        end else if (sample.valid) begin
          axis_value[g] <= axis_next[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire logic in_space;
  wire logic writable;
  wire logic wr_enable;
  wire logic wr_pin_config;
  wire logic wr_lower;
  wire logic wr_upper;
  wire logic rd_status;
  wire logic rd_axis_three_msb;
  wire logic latched;

  // only the common 8-bit space is decoded
  assign in_space = (req.addr >= SPACE_FIRST) && (req.addr <= SPACE_LAST);
  assign writable = in_space && (req.addr > RO_LAST);
  assign wr_enable = req.wr && writable &&
                     (req.addr == ADDR_IRQ_ENABLE_BITS);
  assign wr_pin_config = req.wr && writable &&
                         (req.addr == ADDR_PIN_CONFIG);
  assign wr_lower = req.wr && writable &&
                    (req.addr == ADDR_LOWER_LIMIT_LEVEL);
  assign wr_upper = req.wr && writable &&
                    (req.addr == ADDR_UPPER_LIMIT_LEVEL);
  assign rd_status = req.rd && (req.addr == ADDR_IRQ_STATUS_FLAGS);
  assign rd_axis_three_msb = req.rd && (req.addr == ADDR_AXIS_THREE_MSB);
  assign latched = pin_config[BIT_LATCH];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // enables reset to all high axes disabled, overflow off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_enable_bits <= RST_IRQ_ENABLE;
    end else if (wr_enable) begin
      irq_enable_bits <= req.wdata & MASK_IRQ_ENABLE;
    end
  end

  // pin enable and polarity live here
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_config <= RST_PIN_CONFIG;
    end else if (wr_pin_config) begin
      pin_config <= req.wdata & MASK_PIN_CONFIG;
    end
  end

  // limit levels; the lower one is only stored for its own engine
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lower_limit_level <= RST_LIMIT;
      upper_limit_level <= RST_LIMIT;
    end else begin
      if (wr_lower) begin
        lower_limit_level <= req.wdata;
      end
      if (wr_upper) begin
        upper_limit_level <= req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  wire logic [NUM_AXES-1:0] high_event;
  wire logic overflow_event;
  logic [7:0] sample_flags;
  wire logic [7:0] kept_flags;
  wire logic [7:0] next_status;

  // per-axis high event, gated by its enable
  assign high_event = axis_above & high_enabled;
  assign overflow_event = |sample.overflow;
  // flags placed bit by bit, so no shifted one-bit value is widened
  always_comb begin
    sample_flags = 8'h00;
    sample_flags[BIT_OVERFLOW] = overflow_event;
    sample_flags[BIT_HIGH_FIRST +: NUM_AXES] = high_event;
  end
  // latched keeps old flags unless a status read clears them
  assign kept_flags = (latched && !rd_status) ? irq_status_flags : 8'h00;
  // new flags land only with a new sample; set beats read-clear
  assign next_status = sample.valid ? (kept_flags | sample_flags) :
                       ((latched && rd_status) ? 8'h00 : irq_status_flags);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_status_flags <= RST_IRQ_STATUS;
    end else begin
      irq_status_flags <= next_status;
    end
  end

  // data ready status: set by a sample, cleared once the last
  // data byte has been read, unless a new sample arrives then
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ready_status <= 1'b0;
    end else if (sample.valid) begin
      ready_status <= 1'b1;
    end else if (rd_axis_three_msb) begin
      ready_status <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt pin
  // ---------------------------------------------------------------
  wire logic irq_active;
  wire logic next_irq_out;

  // any enabled axis above the scaled limit
  // overflow reaches the pin only through its enable
  assign irq_active =
    (|irq_status_flags[BIT_HIGH_FIRST +: NUM_AXES]) ||
    (irq_status_flags[BIT_OVERFLOW] && irq_enable_bits[BIT_OVERFLOW]);
  assign next_irq_out = pin_config[BIT_POLARITY] ? irq_active : !irq_active;

  // pin follows the flags one cycle later; a status read therefore
  // releases it on the edge after the flags clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_out <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      irq_out <= next_irq_out;
      irq_oe <= pin_config[BIT_PIN_ENABLE];
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] read_mux;
  logic read_known;

  // reserved registers read back as zero; unused enable and pin bits read back as stored
  always_comb begin
    read_mux = 8'h00;
    read_known = 1'b1;
    unique case (req.addr)
      ADDR_AXIS_ONE_LSB: read_mux = {axis_value[0][4:0], 3'b000};
      ADDR_AXIS_ONE_MSB: read_mux = axis_value[0][12:5];
      ADDR_AXIS_TWO_LSB: read_mux = {axis_value[1][4:0], 3'b000};
      ADDR_AXIS_TWO_MSB: read_mux = axis_value[1][12:5];
      ADDR_AXIS_THREE_LSB: read_mux = {axis_value[2][6:0], 1'b0};
      ADDR_AXIS_THREE_MSB: read_mux = axis_value[2][14:7];
      ADDR_READY_STATUS: read_mux = {7'h00, ready_status};
      ADDR_IRQ_STATUS_FLAGS: read_mux = irq_status_flags;
      ADDR_IRQ_ENABLE_BITS: read_mux = irq_enable_bits;
      ADDR_PIN_CONFIG: read_mux = pin_config;
      ADDR_LOWER_LIMIT_LEVEL: read_mux = lower_limit_level;
      ADDR_UPPER_LIMIT_LEVEL: read_mux = upper_limit_level;
      default: read_known = 1'b0;
    endcase
  end

  // host identifies an overflowed axis from saturated data
  // read answer one cycle after the request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      reg_rdrive <= 1'b0;
    end else begin
      reg_rdata <= req.rd ? read_mux : 8'h00;
      reg_rvalid <= req.rd;
      // reserved reads leave the data line undriven
      reg_rdrive <= req.rd && in_space && read_known;
    end
  end

endmodule
`default_nettype wire

//--- mag_irq_ctrl_sva.sv
// assertion checker for the threshold and overflow interrupt block
`timescale 1ns/10ps
`default_nettype none
module mag_irq_ctrl_sva
  import mag_irq_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic rst, // async reset
  input wire meas_sample_t sample, // measurement
  input wire reg_req_t req, // register request
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid, // read valid
  input wire logic reg_rdrive, // read drive
  input wire logic irq_out, // pin level
  input wire logic irq_oe // pin enable
);
  logic [7:0] lim, en, cfg;
  // shadow of the upper limit, enable and pin settings, rebuilt from observed writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lim <= RST_LIMIT;
      en <= RST_IRQ_ENABLE;
      cfg <= RST_PIN_CONFIG;
    end else if (req.wr) begin
      if (req.addr == ADDR_UPPER_LIMIT_LEVEL) lim <= req.wdata;
      if (req.addr == ADDR_IRQ_ENABLE_BITS) en <= req.wdata;
      if (req.addr == ADDR_PIN_CONFIG) cfg <= req.wdata;
    end
  end
  // axis one above sixteen times the limit, enabled, not overflowed
  wire logic x_hi = sample.valid && !sample.overflow[0] && !en[3] &&
    (sample.field_value_axis_one > $signed({2'b0, lim, 4'b0}));
  wire logic ov_on = sample.valid && (|sample.overflow) && en[6];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_rd_answered: assert property (
    req.rd |=> reg_rvalid) else $error("read not answered");
  chk_rvalid_cause: assert property (
    reg_rvalid |-> $past(req.rd)) else $error("answer without read");
  chk_drive_in_answer: assert property (
    reg_rdrive |-> reg_rvalid) else $error("drive outside answer");
  chk_unmapped_quiet: assert property (
    req.rd && (req.addr < SPACE_FIRST || req.addr > SPACE_LAST)
    |=> !reg_rdrive && reg_rdata == 8'h00) else $error("unmapped driven");
  chk_limit_readback: assert property (
    req.rd && !req.wr && req.addr == ADDR_UPPER_LIMIT_LEVEL
    |=> reg_rdrive && reg_rdata == $past(lim)) else $error("limit read");
  chk_status_rsvd: assert property (
    req.rd && req.addr == ADDR_IRQ_STATUS_FLAGS
    |=> reg_rdata[2:0] == 3'b000 && !reg_rdata[7]) else $error("rsvd");
  chk_oe_follows: assert property (
    $stable(cfg[BIT_PIN_ENABLE]) |-> irq_oe == cfg[BIT_PIN_ENABLE])
    else $error("pin enable wrong");
  chk_high_pin: assert property (
    x_hi && cfg[6] |-> ##2 irq_out == cfg[0]) else $error("high missed");
  chk_ovf_pin: assert property (
    ov_on && cfg[6] |-> ##2 irq_out == cfg[0]) else $error("ovf missed");
  cov_high: cover property (x_hi && cfg[6]);
  cov_ovf: cover property (ov_on);
  cov_status: cover property (req.rd && req.addr == 8'h4A ##1 reg_rvalid);
endmodule
bind mag_irq_ctrl mag_irq_ctrl_sva mag_irq_ctrl_sva_i (.sys_clk(sys_clk),
  .rst(rst), .sample(sample), .req(req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .reg_rdrive(reg_rdrive), .irq_out(irq_out),
  .irq_oe(irq_oe));
`default_nettype wire

//--- mag_irq_ctrl_tb.sv
// self-checking bench for the threshold and overflow interrupt block
`timescale 1ns/10ps
`default_nettype none
module mag_irq_ctrl_tb
  import mag_irq_pkg::*;
;
  logic sys_clk, rst, reg_rvalid, reg_rdrive, irq_out, irq_oe, dr;
  meas_sample_t sample;
  reg_req_t req;
  logic [7:0] reg_rdata, rd;
  logic [2:0] sat;
  int mismatches, checks, cycles;
  mag_irq_ctrl mag_irq_ctrl_i (.sys_clk(sys_clk), .rst(rst),
    .sample(sample), .req(req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_rdrive(reg_rdrive),
    .irq_out(irq_out), .irq_oe(irq_oe));
  mag_host_model mag_host_model_i (.sys_clk(sys_clk), .req(req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_rdrive(reg_rdrive));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // the whole run needs about 130 cycles; a hang ends here
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  // ----------
  // helpers
  // ----------
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mag_host_model_i.write(a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    mag_host_model_i.read(a, rd, dr);
    check("read data", rd, exp);
    check("read drive", {7'h0, dr}, 8'h01);
  endtask
  // one sample, then two edges so the pin has followed
  task automatic meas(input logic [2:0] ov, input int x, y, z);
    @(posedge sys_clk);
    #1;
    sample = '{1'b1, ov, 13'(x), 13'(y), 15'(z)};
    @(posedge sys_clk);
    #1;
    sample.valid = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic pin(input logic lvl, input logic oe);
    check("irq pin", {6'h0, irq_oe, irq_out}, {6'h0, oe, lvl});
  endtask
  initial begin
    rst = 1'b1;
    sample = '0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rchk(ADDR_IRQ_STATUS_FLAGS, 8'h00);
    rchk(ADDR_IRQ_ENABLE_BITS, 8'h3F);
    rchk(ADDR_PIN_CONFIG, 8'h07);
    rchk(ADDR_UPPER_LIMIT_LEVEL, 8'h00);
    pin(1'b0, 1'b0);
    // read-only space keeps its contents, outside space is undriven
    wr(ADDR_IRQ_STATUS_FLAGS, 8'hFF);
    wr(ADDR_AXIS_ONE_MSB, 8'h55);
    rchk(ADDR_IRQ_STATUS_FLAGS, 8'h00);
    rchk(ADDR_AXIS_ONE_MSB, 8'h00);
    mag_host_model_i.read(8'h72, rd, dr);
    check("unmapped drive", {7'h0, dr}, 8'h00);
    // a reserved register inside the space leaves the line undriven
    mag_host_model_i.read(8'h60, rd, dr);
    check("reserved drive", {7'h0, dr}, 8'h00);
    // limit 6 is 96; axes stay off until an enable bit goes low
    wr(ADDR_UPPER_LIMIT_LEVEL, 8'h06);
    wr(ADDR_PIN_CONFIG, 8'h43);
    meas(3'b000, 200, 200, 200);
    pin(1'b0, 1'b1);
    rchk(ADDR_IRQ_STATUS_FLAGS, 8'h00);
    wr(ADDR_IRQ_ENABLE_BITS, 8'h37);
    meas(3'b000, 96, 0, 0);
    pin(1'b0, 1'b1);
    meas(3'b000, 97, 0, 0);
    pin(1'b1, 1'b1);
    // latched: a quiet sample keeps the flag, the status read drops it
    meas(3'b000, 0, 0, 0);
    rchk(ADDR_IRQ_STATUS_FLAGS, 8'h08);
    @(posedge sys_clk);
    #1;
    pin(1'b0, 1'b1);
    // largest limit 4080 on all axes, axis one at the boundary
    wr(ADDR_UPPER_LIMIT_LEVEL, 8'hFF);
    wr(ADDR_IRQ_ENABLE_BITS, 8'h07);
    meas(3'b000, 4080, 4095, 4081);
    rchk(ADDR_IRQ_STATUS_FLAGS, 8'h30);
    // low-active pin: idle high, active low
    wr(ADDR_PIN_CONFIG, 8'h42);
    meas(3'b000, 0, 0, 0);
    pin(1'b1, 1'b1);
    meas(3'b000, 0, 0, 4095);
    pin(1'b0, 1'b1);
    rchk(ADDR_IRQ_STATUS_FLAGS, 8'h20);
    // overflow with its pin gate closed, then open
    wr(ADDR_PIN_CONFIG, 8'h43);
    wr(ADDR_IRQ_ENABLE_BITS, 8'h3F);
    meas(3'b101, 100, 5, 100);
    pin(1'b0, 1'b1);
    mag_host_model_i.find_overflow(sat);
    check("saturated axes", {5'h0, sat}, 8'h05);
    rchk(ADDR_AXIS_TWO_LSB, 8'h28);
    rchk(ADDR_IRQ_STATUS_FLAGS, 8'h40);
    wr(ADDR_IRQ_ENABLE_BITS, 8'h7F);
    meas(3'b010, 0, 0, 0);
    pin(1'b1, 1'b1);
    rchk(ADDR_IRQ_STATUS_FLAGS, 8'h40);
    // non-latched: reads keep the flag, a quiet sample drops it
    wr(ADDR_PIN_CONFIG, 8'h41);
    meas(3'b001, 0, 0, 0);
    rchk(ADDR_IRQ_STATUS_FLAGS, 8'h40);
    rchk(ADDR_IRQ_STATUS_FLAGS, 8'h40);
    meas(3'b000, 0, 0, 0);
    pin(1'b0, 1'b1);
    // pin released: level still follows the enabled overflow
    wr(ADDR_PIN_CONFIG, 8'h01);
    meas(3'b001, 0, 0, 0);
    pin(1'b1, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire

//--- mag_irq_pkg.sv
// constants and carrier types for the magnetometer threshold/overflow logic
//
// How it works
// - per-axis high status set above limit
// - pin asserts on raw above limit times sixteen
// - high enables active low, reset disabled
// - overflow saturates axis to most negative code
// - shared overflow flag at status bit six
// - overflow drives pin only when enabled
// - 8-bit registers spanning 0x40 through 0x71
// - reserved bits of enable and pin config take writes (masks 0xFF), read back as stored
// - reserved reads may leave data output undriven
// - registers 0x40 to 0x4A are read-only
// - latched holds until status read; else remeasure
// - pin driven only when pin enable set
// - status updates with new field data
// - pin polarity follows polarity bit, default high
package mag_irq_pkg;

  // ---------------------------------------------------------------
  // register space
  // ---------------------------------------------------------------
  localparam logic [7:0] SPACE_FIRST = 8'h40;
  localparam logic [7:0] SPACE_LAST = 8'h71;
  localparam logic [7:0] RO_LAST = 8'h4A;
  localparam logic [7:0] ADDR_AXIS_ONE_LSB = 8'h42;
  localparam logic [7:0] ADDR_AXIS_ONE_MSB = 8'h43;
  localparam logic [7:0] ADDR_AXIS_TWO_LSB = 8'h44;
  localparam logic [7:0] ADDR_AXIS_TWO_MSB = 8'h45;
  localparam logic [7:0] ADDR_AXIS_THREE_LSB = 8'h46;
  localparam logic [7:0] ADDR_AXIS_THREE_MSB = 8'h47;
  localparam logic [7:0] ADDR_READY_STATUS = 8'h48;
  localparam logic [7:0] ADDR_IRQ_STATUS_FLAGS = 8'h4A;
  localparam logic [7:0] ADDR_IRQ_ENABLE_BITS = 8'h4D;
  localparam logic [7:0] ADDR_PIN_CONFIG = 8'h4E;
  localparam logic [7:0] ADDR_LOWER_LIMIT_LEVEL = 8'h4F;
  localparam logic [7:0] ADDR_UPPER_LIMIT_LEVEL = 8'h50;

  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h3F;
  localparam logic [7:0] RST_PIN_CONFIG = 8'h07;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [7:0] MASK_IRQ_ENABLE = 8'hFF;
  localparam logic [7:0] MASK_PIN_CONFIG = 8'hFF;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_HIGH_FIRST = 3;
  localparam int BIT_OVERFLOW = 6;
  localparam int BIT_PIN_ENABLE = 6;
  localparam int BIT_LATCH = 1;
  localparam int BIT_POLARITY = 0;
  localparam int NUM_AXES = 3;

  // ---------------------------------------------------------------
  // data widths, saturation codes, limit scaling
  // ---------------------------------------------------------------
  localparam int HORIZ_WIDTH = 13;
  localparam int VERT_WIDTH = 15;
  localparam int LIMIT_SHIFT = 4;
  localparam logic signed [VERT_WIDTH-1:0] SAT_HORIZ = -15'sd4096;
  localparam logic signed [VERT_WIDTH-1:0] SAT_VERT = -15'sd16384;

  // one finished measurement from the conversion engine
  typedef struct packed {
    logic valid;
    logic [NUM_AXES-1:0] overflow;
    logic signed [HORIZ_WIDTH-1:0] field_value_axis_one;
    logic signed [HORIZ_WIDTH-1:0] field_value_axis_two;
    logic signed [VERT_WIDTH-1:0] field_value_axis_three;
  } meas_sample_t;

  // register access from the serial interface front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage
